// File: src/pfs_pkg.sv
// shared constants and types for the power fail supervisor
`default_nettype none

package pfs_pkg;

    // ****************************************************************
    // timebase
    // ****************************************************************
    localparam int unsigned CLK_KHZ     = 100_000;  // 100 MHz ref_clk
    localparam int unsigned HOLD_MS     = 250;      // post-event reset hold
    localparam int unsigned DEBOUNCE_MS = 10;       // button must stay low this long
    localparam int unsigned WD_SHORT_MS = 250;
    localparam int unsigned WD_MID_MS   = 500;
    localparam int unsigned WD_LONG_MS  = 1000;

    // least times, already whole cycles at this rate
    localparam int unsigned HOLD_CYC     = HOLD_MS * CLK_KHZ;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
    localparam int unsigned WD_MID_CYC   = WD_MID_MS * CLK_KHZ;
    localparam int unsigned WD_LONG_CYC  = WD_LONG_MS * CLK_KHZ;

    localparam int unsigned CNT_W = 27;  // holds 1000 ms of cycles

    // ****************************************************************
    // pin synchroniser layout
    // ****************************************************************
    localparam int unsigned SYN_N      = 5;
    localparam int unsigned SYN_SUPPLY = 0;
    localparam int unsigned SYN_BUTTON = 1;
    localparam int unsigned SYN_KICK   = 2;
    localparam int unsigned SYN_SEL_LO = 3;
    localparam int unsigned SYN_SEL_HI = 4;
    localparam logic [4:0]  SYN_RST    = 5'h06;  // supply bad, button and kick idle high

    // watchdog timeout select
    localparam logic [1:0] WD_OFF   = 2'h0;
    localparam logic [1:0] WD_SHORT = 2'h1;
    localparam logic [1:0] WD_MID   = 2'h2;
    localparam logic [1:0] WD_LONG  = 2'h3;

    // supervisor states, gray along fail -> hold -> run
    typedef enum logic [1:0] {
        PFS_FAIL = 2'h0,
        PFS_HOLD = 2'h1,
        PFS_RUN  = 2'h3
    } pfs_state_t;

    // byte-lane memory enables, active low
    typedef struct packed {
        logic hi_n;
        logic lo_n;
    } pfs_lane_t;

    localparam pfs_lane_t LANES_OFF = 2'h3;

endpackage

`default_nettype wire

// File: src/pfs_top.sv
// power fail supervisor: supply reset, button debounce, watchdog, sram gating
`default_nettype none

// What this block does
// - memory enables pass only while supply good
// - high request drives high, low drives low
// - supply failure forces reset output active immediately
// - reset held 250 ms after supply recovers
// - debounced button gives at least 250 ms reset
// - watchdog kick needed; expiry resets; selectable timeout
module pfs_top #(
    parameter int unsigned HOLD_CYCLES  = pfs_pkg::HOLD_CYC,
    parameter int unsigned DEB_CYCLES   = pfs_pkg::DEBOUNCE_CYC,
    parameter int unsigned WD_SHORT_CYC = pfs_pkg::WD_SHORT_CYC,
    parameter int unsigned WD_MID_CYC   = pfs_pkg::WD_MID_CYC,
    parameter int unsigned WD_LONG_CYC  = pfs_pkg::WD_LONG_CYC
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // supply comparator, high while in tolerance
    input  wire logic              supply_ok,
    // pushbutton and watchdog pins
    input  wire logic              button_n,
    input  wire logic              watchdog_kick_n,
    input  wire logic [1:0]        wd_timeout_sel,
    // processor byte-lane requests and gated memory selects
    input  wire pfs_pkg::pfs_lane_t mem_request_n,
    output logic                   high_mem_select_out_n,
    output logic                   low_mem_select_out_n,
    // reset to the processor
    output logic                   reset_out_n
);
    import pfs_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [SYN_N-1:0] pins;
    logic [SYN_N-1:0] s1_r, s2_r, s3_r, clean_r;

    assign pins = {wd_timeout_sel, watchdog_kick_n, button_n, supply_ok};

    // three flops; a change is accepted once stages two and three agree
    for (genvar i = 0; i < SYN_N; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                s1_r[i]    <= SYN_RST[i];
                s2_r[i]    <= SYN_RST[i];
                s3_r[i]    <= SYN_RST[i];
                clean_r[i] <= SYN_RST[i];
            end else begin
                s1_r[i]    <= pins[i];
                s2_r[i]    <= s1_r[i];
                s3_r[i]    <= s2_r[i];
                clean_r[i] <= (s2_r[i] == s3_r[i]) ? s3_r[i] : clean_r[i];
            end
        end
    end

    wire       good_sync = clean_r[SYN_SUPPLY];
    wire       btn_low   = ~clean_r[SYN_BUTTON];
    wire [1:0] wd_sel    = clean_r[SYN_SEL_HI:SYN_SEL_LO];

    // ****************************************************************
    // sram lane gating
    // ****************************************************************
    // raw pin closes the gate at once; sync copy keeps it shut until settled
    wire mem_ok = supply_ok & good_sync;
    assign high_mem_select_out_n = mem_ok ? mem_request_n.hi_n : LANES_OFF.hi_n;
    assign low_mem_select_out_n  = mem_ok ? mem_request_n.lo_n : LANES_OFF.lo_n;

    // ****************************************************************
    // pushbutton debounce
    // ****************************************************************
    logic [CNT_W-1:0] deb_cnt_r;
    logic             btn_taken_r;

    wire deb_done  = (deb_cnt_r == CNT_W'(DEB_CYCLES - 1));
    wire press_evt = btn_low & deb_done & ~btn_taken_r;

    // one event per press: a held button does not retrigger
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            deb_cnt_r   <= '0;
            btn_taken_r <= 1'b0;
        end else begin
            deb_cnt_r   <= (btn_low && !deb_done) ? deb_cnt_r + 1'b1
                         : (btn_low ? deb_cnt_r : '0);
            btn_taken_r <= btn_low & (btn_taken_r | deb_done);
        end
    end

    // ****************************************************************
    // watchdog
    // ****************************************************************
    logic             kick_d_r;
    logic [CNT_W-1:0] wd_cnt_r;
    pfs_state_t       state_r, state_nxt;

    wire kick_evt = kick_d_r & ~clean_r[SYN_KICK];  // falling edge of strobe
    wire [CNT_W-1:0] wd_limit =
        (wd_sel == WD_SHORT) ? CNT_W'(WD_SHORT_CYC - 1) :
        (wd_sel == WD_MID)   ? CNT_W'(WD_MID_CYC - 1) :
                               CNT_W'(WD_LONG_CYC - 1);
    wire wd_run    = (state_r == PFS_RUN) && (wd_sel != WD_OFF);
    wire wd_expire = wd_run && !kick_evt && (wd_cnt_r == wd_limit);

    // counts only while the processor runs; a kick or selection off clears it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            kick_d_r <= 1'b1;
            wd_cnt_r <= '0;
        end else begin
            kick_d_r <= clean_r[SYN_KICK];
            wd_cnt_r <= (!wd_run || kick_evt || wd_expire) ? '0 : wd_cnt_r + 1'b1;
        end
    end

    // ****************************************************************
    // reset sequencer
    // ****************************************************************
    logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;

    wire hold_done = (hold_cnt_r == CNT_W'(HOLD_CYCLES - 1));
    wire restart   = press_evt | wd_expire;

    // a fresh event in hold or run sends us back to the start of the hold; in fail it is ignored
    always_comb begin
        state_nxt    = state_r;
        hold_cnt_nxt = '0;
        case (state_r)
            PFS_FAIL: begin
                if (good_sync) begin
                    state_nxt = PFS_HOLD;
                end
            end
            PFS_HOLD: begin
                if (!good_sync) begin
                    state_nxt = PFS_FAIL;
                end else if (restart) begin
                    hold_cnt_nxt = '0;
                end else if (hold_done) begin
                    state_nxt = PFS_RUN;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 1'b1;
                end
            end
            PFS_RUN: begin
                if (!good_sync) begin
                    state_nxt = PFS_FAIL;
                end else if (restart) begin
                    state_nxt = PFS_HOLD;
                end
            end
            default: begin
                state_nxt = PFS_FAIL;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= PFS_FAIL;
            hold_cnt_r <= '0;
        end else begin
            state_r    <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // raw comparator forces reset with no synchroniser latency
    assign reset_out_n = (state_r == PFS_RUN) & supply_ok;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_hold_complete;
        (state_r == PFS_HOLD) && hold_done && good_sync && !restart;
    endsequence

    property p_gate_closed;
        @(posedge ref_clk) disable iff (!nrst)
        !supply_ok |-> high_mem_select_out_n && low_mem_select_out_n;
    endproperty
    a_gate_closed: assert property (p_gate_closed) else $error("lane open on bad supply");

    property p_lane_map;
        @(posedge ref_clk) disable iff (!nrst)
        mem_ok |-> (high_mem_select_out_n == mem_request_n.hi_n)
                && (low_mem_select_out_n == mem_request_n.lo_n);
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane mapping wrong");

    property p_fail_reset;
        @(posedge ref_clk) disable iff (!nrst)
        !supply_ok |-> !reset_out_n ##1 !reset_out_n;
    endproperty
    a_fail_reset: assert property (p_fail_reset) else $error("reset not forced");

    property p_release;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(reset_out_n) |-> $past(state_r) == PFS_HOLD
                             ? $past(hold_cnt_r) == CNT_W'(HOLD_CYCLES - 1) : 1'b1;
    endproperty
    a_release: assert property (p_release) else $error("reset released early");

    property p_hold_end;
        @(posedge ref_clk) disable iff (!nrst)
        s_hold_complete |=> state_r == PFS_RUN;
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold did not end");

    property p_press;
        @(posedge ref_clk) disable iff (!nrst)
        (press_evt && good_sync) |=> (state_r == PFS_HOLD) && (hold_cnt_r == '0) && !reset_out_n;
    endproperty
    a_press: assert property (p_press) else $error("press gave no reset");

    property p_wd;
        @(posedge ref_clk) disable iff (!nrst)
        (wd_expire && good_sync) |=> !reset_out_n && (wd_cnt_r == '0);
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog expiry ignored");

    property p_restart;
        @(posedge ref_clk) disable iff (!nrst)
        ((state_r == PFS_HOLD) && good_sync && restart) |=> hold_cnt_r == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("hold not restarted");

endmodule // pfs_top

`default_nettype wire

// File: tb/pfs_host_model.sv
// host processor model: byte-lane requests and watchdog kicks
`default_nettype none

module pfs_host_model (
    // clock
    input  wire logic                ref_clk,
    // what the bench asks of the processor
    input  wire logic [1:0]          lanes,
    input  wire logic                kick_en,
    // processor pins
    output var pfs_pkg::pfs_lane_t   mem_request_n,
    output var logic                 watchdog_kick_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import pfs_pkg::*;

    // ****************************************************************
    // pin driving
    // ****************************************************************
    logic [3:0] tick_r;

    // pins idle until the first falling edge, then follow the bench just after each
    // falling edge so the design never sees a race; one process owns them all
    initial begin
        tick_r          = 4'h0;
        mem_request_n   = LANES_OFF;
        watchdog_kick_n = 1'b1;
        forever begin
            @(negedge ref_clk);
            mem_request_n   <= lanes;
            tick_r          <= tick_r + 4'h1;
            watchdog_kick_n <= ~(kick_en & tick_r[3]);
        end
    end
endmodule // pfs_host_model

`default_nettype wire

// File: tb/pfs_top_tb.sv
// self-checking bench for the power fail supervisor
`default_nettype none

module pfs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfs_pkg::*;

    // ****************************************************************
    // signals
    // ****************************************************************
    localparam int HOLD = 20;
    localparam int DEB  = 5;
    localparam int WD1  = 40;   // short timeout; mid doubles it, long quadruples it
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       supply_ok = 1'b1;
    logic       button_n = 1'b1;
    logic [1:0] wd_sel = WD_OFF;
    logic       kick_en = 1'b0;
    logic [1:0] lanes = 2'h0;
    pfs_lane_t  req_n;
    logic       kick_n;
    logic       hi_n;
    logic       lo_n;
    logic       rst_n;
    int         bad_count = 0;
    int         n_tests = 0;

    pfs_top #(.HOLD_CYCLES(HOLD), .DEB_CYCLES(DEB), .WD_SHORT_CYC(WD1),
              .WD_MID_CYC(2 * WD1), .WD_LONG_CYC(4 * WD1)) i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .supply_ok(supply_ok), .button_n(button_n),
        .watchdog_kick_n(kick_n), .wd_timeout_sel(wd_sel), .mem_request_n(req_n),
        .high_mem_select_out_n(hi_n), .low_mem_select_out_n(lo_n), .reset_out_n(rst_n));

    pfs_host_model i_host (.ref_clk(ref_clk), .lanes(lanes), .kick_en(kick_en),
                           .mem_request_n(req_n), .watchdog_kick_n(kick_n));

    // 100 MHz
    initial forever #5 ref_clk = ~ref_clk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk_bit(string what, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_cnt(string what, int lo, int hi, int got);
        n_tests++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // cycles until reset releases; bounded so a stuck reset cannot hang
    task automatic cnt_low(output int c);
        c = 0;
        while (rst_n !== 1'b1 && c < 2000) begin
            @(negedge ref_clk);
            c++;
        end
    endtask

    // reset-low cycles over a fixed span; a watchdog that fires and recovers
    // inside the span still shows up here, unlike a single late look
    task automatic cnt_span(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(negedge ref_clk);
            if (rst_n !== 1'b1) begin
                c++;
            end
        end
    endtask

    task automatic wait_low(output int c);
        c = 0;
        while (rst_n !== 1'b0 && c < 2000) begin
            @(negedge ref_clk);
            c++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // every lane pattern, then a supply drop and recovery with lanes requested
    task automatic t_supply();
        int n;
        for (int i = 0; i < 4; i++) begin
            lanes = 2'(i);
            repeat (2) @(negedge ref_clk);
            chk_bit("high select", lanes[1], hi_n);
            chk_bit("low select", lanes[0], lo_n);
        end
        lanes = 2'h0;
        repeat (2) @(negedge ref_clk);
        supply_ok = 1'b0;
        #1;
        chk_bit("high select off", 1'b1, hi_n);
        chk_bit("low select off", 1'b1, lo_n);
        chk_bit("reset on fail", 1'b0, rst_n);
        repeat (10) @(negedge ref_clk);
        supply_ok = 1'b1;
        cnt_low(n);
        chk_cnt("supply hold", HOLD, HOLD + 6, n);
        chk_bit("high select back", 1'b0, hi_n);
        lanes = 2'h3;
    endtask

    // bounce ignored, real press held, then a fresh press and a second one inside its hold
    task automatic t_button();
        int n;
        button_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        button_n = 1'b1;
        repeat (20) @(negedge ref_clk);
        chk_bit("bounce ignored", 1'b1, rst_n);
        button_n = 1'b0;
        wait_low(n);
        chk_cnt("debounce", DEB, DEB + 6, n);
        button_n = 1'b1;
        cnt_low(n);
        chk_cnt("button hold", HOLD, HOLD + 2, n);
        button_n = 1'b0;
        wait_low(n);
        button_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        button_n = 1'b0;
        repeat (DEB + 8) @(negedge ref_clk);
        button_n = 1'b1;
        cnt_low(n);
        chk_cnt("restarted hold", HOLD - 8, HOLD, n);
    endtask

    // each timeout code expires, kicks keep it quiet, off never fires
    task automatic t_wdog();
        int n;
        for (int s = 1; s < 4; s++) begin
            wd_sel = 2'(s);
            wait_low(n);
            chk_cnt("watchdog expiry", WD1 << (s - 1), (WD1 << (s - 1)) + 8, n);
            wd_sel = WD_OFF;
            cnt_low(n);
        end
        cnt_span(400, n);
        chk_cnt("watchdog off", 0, 0, n);
        kick_en = 1'b1;
        wd_sel = WD_SHORT;
        cnt_span(200, n);
        chk_cnt("watchdog kicked", 0, 0, n);
        wd_sel = WD_OFF;
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        int n;
        repeat (16) @(negedge ref_clk);
        chk_bit("reset during nrst", 1'b0, rst_n);
        chk_bit("high select during nrst", 1'b1, hi_n);
        chk_bit("low select during nrst", 1'b1, lo_n);
        nrst = 1'b1;
        cnt_low(n);
        chk_cnt("boot hold", HOLD, HOLD + 6, n);
        t_supply();
        t_button();
        t_wdog();
        finish_test();
    end

    // whole run is little over a thousand cycles; this is far beyond it
    initial begin
        #200us;
        bad_count++;
        finish_test();
    end
endmodule // pfs_top_tb

`default_nettype wire
